// ---- rtl/mre_defines.svh ----
`ifndef MRE_DEFINES_SVH
`define MRE_DEFINES_SVH

// 14-bit instruction encodings
`define MRE_OP_W          14
`define MRE_DATA_W        8
`define MRE_FADDR_W       7
`define MRE_PC_W          13
`define MRE_NOP_WORD      14'h0000
`define MRE_RETURN_WORD   14'h0008
`define MRE_RETINT_WORD   14'h0009
`define MRE_COPY_TOP      7'h01
`define MRE_LOAD_TOP      4'hc
`define MRE_RETLIT_TOP    4'hd
`define MRE_INT_EN_BIT    7
`define MRE_W_RESET       8'h00

`endif

// ---- rtl/mre_pkg.sv ----
package mre_pkg;

  typedef enum logic [2:0] {
    MRE_CL_NONE,
    MRE_CL_NOP,
    MRE_CL_COPY,
    MRE_CL_LOAD,
    MRE_CL_RETINT,
    MRE_CL_RETLIT,
    MRE_CL_RETURN
  } mre_class_t;

  typedef struct packed {
    mre_class_t  cls;
    logic [6:0]  faddr;
    logic [7:0]  literal;
  } mre_dec_t;

  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } mre_fwrite_t;

endpackage

// ---- rtl/mre_decode.sv ----
`timescale 1ns/100ps
`include "mre_defines.svh"

module mre_decode (
  // instruction word
  input  wire logic [13:0]     instr_in,
  // decoded result
  output mre_pkg::mre_dec_t    dec_out
);

  always_comb begin
    dec_out.cls     = mre_pkg::MRE_CL_NONE;
    dec_out.faddr   = instr_in[6:0];
    dec_out.literal = instr_in[7:0];
    if (instr_in == `MRE_NOP_WORD) begin
      dec_out.cls = mre_pkg::MRE_CL_NOP;
    end else if (instr_in == `MRE_RETURN_WORD) begin
      dec_out.cls = mre_pkg::MRE_CL_RETURN;
    end else if (instr_in == `MRE_RETINT_WORD) begin
      dec_out.cls = mre_pkg::MRE_CL_RETINT;
    end else if (instr_in[13:7] == `MRE_COPY_TOP) begin
      dec_out.cls = mre_pkg::MRE_CL_COPY;
    end else if (instr_in[13:10] == `MRE_LOAD_TOP) begin
      // don't-care bits 9:8 ignored
      dec_out.cls = mre_pkg::MRE_CL_LOAD;
    end else if (instr_in[13:10] == `MRE_RETLIT_TOP) begin
      dec_out.cls = mre_pkg::MRE_CL_RETLIT;
    end
  end

endmodule

// ---- rtl/mre_exec.sv ----
`timescale 1ns/100ps
`include "mre_defines.svh"

module mre_exec #(
  parameter int DATA_W  = `MRE_DATA_W,
  parameter int FADDR_W = `MRE_FADDR_W,
  parameter int PC_W    = `MRE_PC_W,
  parameter int OP_W    = `MRE_OP_W
) (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  // instruction issue
  input  wire logic                 instr_valid_in,
  input  wire logic [OP_W-1:0]      instr_in,
  output logic                      busy_out,
  output logic                      done_out,
  output logic                      handled_out,
  // working register
  output logic [DATA_W-1:0]         w_out,
  // file register write port
  output mre_pkg::mre_fwrite_t      fwrite_out,
  // stack pop, program counter load and program counter advance
  input  wire logic [PC_W-1:0]      top_of_stack_in,
  output logic                      stack_pop_out,
  output logic                      pc_load_out,
  output logic [PC_W-1:0]           pc_value_out,
  output logic                      pc_advance_out,
  // interrupt control
  output logic                      int_en_set_out,
  output logic [DATA_W-1:0]         int_en_mask_out
);

  typedef enum logic [0:0] {ST_ISSUE, ST_SECOND} mre_state_t;

  logic                   rst_s1_q;
  logic                   rst_s2_q;
  mre_pkg::mre_dec_t      dec;
  mre_state_t             state_q, state_d;
  logic [DATA_W-1:0]      w_q, w_d;
  mre_pkg::mre_fwrite_t   fw_q, fw_d;
  logic                   pop_q, pop_d;
  logic                   pcl_q, pcl_d;
  logic [PC_W-1:0]        pcv_q, pcv_d;
  logic                   adv_q, adv_d;
  logic                   int_en_q, int_en_d;
  logic                   done_q, done_d;

  // the encodings fix word, data and address widths; only PC may vary
  if (DATA_W != 8 || FADDR_W != 7 || OP_W != 14) begin : g_bad_width
    $error("mre_exec: widths are fixed by the instruction encoding");
  end
  if (PC_W < 1) begin : g_bad_pc
    $error("mre_exec: program counter needs at least one bit");
  end
  if (`MRE_INT_EN_BIT >= DATA_W) begin : g_bad_bit
    $error("mre_exec: enable bit outside the control register");
  end

  // release synchroniser for the reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  mre_decode u_decode (
    .instr_in (instr_in),
    .dec_out  (dec)
  );

  // words offered while busy are dropped, the core must re-present them
  assign busy_out    = (state_q == ST_SECOND);
  assign handled_out = instr_valid_in && !busy_out &&
                       (dec.cls != mre_pkg::MRE_CL_NONE);

  // sequence group: state, completion and program counter advance
  always_comb begin
    state_d = ST_ISSUE;
    done_d  = 1'b0;
    adv_d   = 1'b0;
    case (state_q)
      ST_ISSUE: begin
        if (handled_out) begin
          case (dec.cls)
            mre_pkg::MRE_CL_NOP,
            mre_pkg::MRE_CL_COPY,
            mre_pkg::MRE_CL_LOAD: begin
              adv_d  = 1'b1;
              done_d = 1'b1;
            end
            mre_pkg::MRE_CL_RETINT,
            mre_pkg::MRE_CL_RETLIT,
            mre_pkg::MRE_CL_RETURN: begin
              state_d = ST_SECOND;
            end
            default: begin
              state_d = ST_ISSUE;
            end
          endcase
        end
      end
      ST_SECOND: begin
        // the fetched word is flushed here, so only done rises
        done_d = 1'b1;
      end
      default: begin
        state_d = ST_ISSUE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q <= ST_ISSUE;
      done_q  <= 1'b0;
      adv_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q  <= done_d;
      adv_q   <= adv_d;
    end
  end

  // data group: working register and file write port
  always_comb begin
    w_d  = w_q;
    fw_d = '0;
    if (handled_out) begin
      case (dec.cls)
        mre_pkg::MRE_CL_COPY: begin
          fw_d.we   = 1'b1;
          fw_d.addr = dec.faddr;
          fw_d.data = w_q;
        end
        mre_pkg::MRE_CL_LOAD,
        mre_pkg::MRE_CL_RETLIT: begin
          w_d = dec.literal;
        end
        default: begin
          w_d = w_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      w_q  <= `MRE_W_RESET;
      fw_q <= '0;
    end else begin
      w_q  <= w_d;
      fw_q <= fw_d;
    end
  end

  // return group: stack pop, program counter load, interrupt enable
  // top_of_stack_in is taken on the issue edge only, the stack may move on
  always_comb begin
    pop_d    = 1'b0;
    pcl_d    = 1'b0;
    pcv_d    = pcv_q;
    int_en_d = 1'b0;
    if (handled_out) begin
      case (dec.cls)
        mre_pkg::MRE_CL_RETINT: begin
          pop_d    = 1'b1;
          pcl_d    = 1'b1;
          pcv_d    = top_of_stack_in;
          int_en_d = 1'b1;
        end
        mre_pkg::MRE_CL_RETLIT,
        mre_pkg::MRE_CL_RETURN: begin
          pop_d = 1'b1;
          pcl_d = 1'b1;
          pcv_d = top_of_stack_in;
        end
        default: begin
          pop_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      pop_q    <= 1'b0;
      pcl_q    <= 1'b0;
      pcv_q    <= '0;
      int_en_q <= 1'b0;
    end else begin
      pop_q    <= pop_d;
      pcl_q    <= pcl_d;
      pcv_q    <= pcv_d;
      int_en_q <= int_en_d;
    end
  end

  // set mask: only the enable bit of the control register is raised
  for (genvar b = 0; b < DATA_W; b++) begin : g_mask
    assign int_en_mask_out[b] = int_en_q && (b == `MRE_INT_EN_BIT);
  end

  assign w_out          = w_q;
  assign fwrite_out     = fw_q;
  assign stack_pop_out  = pop_q;
  assign pc_load_out    = pcl_q;
  assign pc_value_out   = pcv_q;
  assign pc_advance_out = adv_q;
  assign int_en_set_out = int_en_q;
  assign done_out       = done_q;

endmodule

// ---- dv/mre_exec_props.sv ----
`timescale 1ns/100ps
module mre_props_chk (
  input logic                 clk_in,
  input logic                 resetn_in,
  input logic                 handled_out,
  input logic [13:0]          instr_in,
  input logic                 done_out,
  input logic [7:0]           w_out,
  input mre_pkg::mre_fwrite_t fwrite_out,
  input logic [12:0]          top_of_stack_in,
  input logic                 stack_pop_out,
  input logic                 pc_load_out,
  input logic [12:0]          pc_value_out,
  input logic                 pc_advance_out,
  input logic                 int_en_set_out,
  input logic [7:0]           int_en_mask_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic fie;
  assign fie = handled_out && instr_in == 14'h0009;
  copy_write_a: assert property (
    handled_out && instr_in[13:7] == 7'h01 |=> done_out
    && fwrite_out == {1'h1, $past(instr_in[6:0]), $past(w_out)})
    else $error("copy write wrong");
  load_w_a: assert property (
    handled_out && instr_in[13:10] == 4'hc |=> done_out
    && pc_advance_out && w_out == $past(instr_in[7:0]))
    else $error("literal load wrong");
  fie_pop_a: assert property (
    fie |=> stack_pop_out && pc_load_out
    && pc_value_out == $past(top_of_stack_in) ##1 done_out && !stack_pop_out)
    else $error("interrupt return pop wrong");
  int_en_mask_a: assert property (
    fie |=> int_en_set_out && int_en_mask_out == 8'h80)
    else $error("enable set missing");
  int_en_cause_a: assert property (
    int_en_set_out |-> $past(fie))
    else $error("stray enable set");
  retlit_load_a: assert property (
    handled_out && instr_in[13:10] == 4'hd |=> pc_load_out
    && w_out == $past(instr_in[7:0])
    && pc_value_out == $past(top_of_stack_in) ##1 done_out)
    else $error("literal return wrong");
  ret_keep_w_a: assert property (
    handled_out && instr_in == 14'h0008 |=> stack_pop_out && !int_en_set_out
    && $stable(w_out) ##1 done_out && $stable(w_out))
    else $error("plain return wrong");
  nop_quiet_a: assert property (
    handled_out && instr_in == 14'h0000 |=> pc_advance_out && done_out
    && $stable(w_out) && !fwrite_out.we && !stack_pop_out)
    else $error("no-op not quiet");
  cover property (fie);
  cover property (handled_out && instr_in[13:10] == 4'hd);
  cover property (fwrite_out.we);
endmodule
bind mre_exec mre_props_chk chk_u (.*);

// ---- dv/mre_exec_tb.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module mre_exec_tb;
  logic                 clk_in, resetn_in = 1'h0, instr_valid_in = 1'h0;
  logic [13:0]          instr_in = 14'h0;
  logic [12:0]          top_of_stack_in = 13'h0, pc_value_out;
  logic                 busy_out, done_out, handled_out, stack_pop_out;
  logic                 pc_load_out, pc_advance_out, int_en_set_out;
  logic [7:0]           w_out, int_en_mask_out;
  mre_pkg::mre_fwrite_t fwrite_out;
  int                   fail_count = 0, checked = 0;
  mre_exec dut_u (.*);
  initial begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end
  // leaves the word valid so the caller can chain or probe refusal
  task automatic go(input logic [13:0] wd, input logic [12:0] t);
    @(negedge clk_in);
    instr_valid_in = 1'h1;
    instr_in = wd;
    top_of_stack_in = t;
    @(negedge clk_in);
    top_of_stack_in = ~t;
  endtask
  task automatic stop();
    instr_valid_in = 1'h0;
    @(negedge clk_in);
  endtask
  task automatic t_move();
    go(14'h305a, 13'h0);
    `CHK(w_out, 8'h5a)
    go(14'h33ff, 13'h0);
    `CHK(w_out, 8'hff)
    go(14'h00ff, 13'h0);
    `CHK(fwrite_out, {1'h1, 7'h7f, 8'hff})
    `CHK(done_out, 1'h1)
    go(14'h0000, 13'h0);
    `CHK({pc_advance_out, fwrite_out.we, w_out}, {2'h2, 8'hff})
    instr_valid_in = 1'h0;
  endtask
  task automatic t_retlit();
    go(14'h3477, 13'h0123);
    `CHK({w_out, pc_value_out}, {8'h77, 13'h0123})
    `CHK({stack_pop_out, pc_load_out, busy_out, handled_out}, 4'he)
    stop();
    `CHK({done_out, stack_pop_out}, 2'h2)
  endtask
  task automatic t_retint();
    go(14'h0009, 13'h1fff);
    `CHK({int_en_set_out, int_en_mask_out}, 9'h180)
    `CHK(pc_value_out, 13'h1fff)
    stop();
    `CHK(done_out, 1'h1)
  endtask
  task automatic t_return();
    go(14'h0008, 13'h0000);
    `CHK({int_en_set_out, w_out, pc_value_out}, {9'h77, 13'h0})
    stop();
    `CHK(done_out, 1'h1)
    go(14'h3fff, 13'h0);
    `CHK({done_out, pc_advance_out, stack_pop_out, handled_out}, 4'h0)
    instr_valid_in = 1'h0;
  endtask
  task automatic test_done();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_in);
    resetn_in = 1'h1;
    repeat (3) @(negedge clk_in);
    t_move();
    t_retlit();
    t_retint();
    t_return();
    test_done();
  end
  initial begin
    #4000;
    fail_count++;
    test_done();
  end
endmodule
